// file: verilog/power_up_defs.vh
/*
 power-up sequencer constants: timing counts, status bit positions,
 reset and shipment values. assumes inclusion by bare name.
*/
`ifndef POWER_UP_DEFS_VH
`define POWER_UP_DEFS_VH
`define CLK_PERIOD_NS      4
`define THRESHOLD_MV       1500
`define STAT_BUSY          0
`define STAT_WEL           1
`define STAT_BP_LO         2
`define STAT_BP_HI         3
`define STAT_PROTECT_ENABLE_FLAG          7
`define WEL_RESET          1'b0
`define BUSY_RESET         1'b0
`define SHIP_NV            3'h0
`define SHIP_BYTE          8'hff
`define OP_WREN            8'h06
`define OP_WRDI            8'h04
`define OP_RDSR            8'h05
`define OP_WRSR            8'h01
`define OP_READ            8'h03
`define OP_WRITE           8'h02
`endif

// file: verilog/nv_store.v
/*
 small memory for the non-volatile status bits and a tiny array.
 assumes its contents survive power removal (modelled: not cleared by reset);
 initial contents are the shipment pattern. registered read data.
*/
`timescale 1ns/100ps
`default_nettype none
`include "power_up_defs.vh"
module nv_store (
  // clock
  input  wire       clk,
  // port
  input  wire       we,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata
);
  reg [7:0] mem [0:15];
  integer i;
  // shipped: ones, protection clear
  // word 15 holds the protection bits, not array data
  initial begin
    for (i = 0; i < 15; i = i + 1)
      mem[i] = `SHIP_BYTE;
    mem[15] = {5'h00, `SHIP_NV};
  end
  always @(posedge clk) begin
    if (we)
      mem[addr] <= wdata;
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// file: verilog/spi_eeprom_power_up_reset.v
/*
 spi eeprom front end: power-on hold-off, interface reset by chip select,
 power-up default status, non-volatile protection bits and small array.
 assumes sck (48 ns period) and pins are asynchronous to MCLK.
*/
//
// Contract
// - ignore commands until supply passes threshold
// - select toggle without clocks resets interface
// - write enable latch cleared at power-up; code clears it on reset only, not on supply return
// - busy bit reads zero at power-up
// - power-up standby, deselected, not paused
// - protection bits kept across power loss
// - shipped array all ones, protection clear
// - protect flag zero: block bits, latch gate
`timescale 1ns/100ps
`default_nettype none
`include "power_up_defs.vh"
module spi_eeprom_power_up_reset (
  // clock and reset
  input  wire       MCLK,
  input  wire       ARST_N,
  // supply monitor
  input  wire [12:0] SUPPLY_MV,
  // spi pins
  input  wire       CS_N,
  input  wire       SCK,
  input  wire       SI,
  input  wire       HOLD_N,
  input  wire       WP_N,
  output reg        SO_O,
  output reg        SO_OE,
  // status
  output reg        POWER_GOOD,
  output reg        STANDBY,
  output reg  [7:0] STATUS
);
  localparam ST_RESET = 3'b001;
  localparam ST_IDLE  = 3'b010;
  localparam ST_XFER  = 3'b100;

  reg        rst1_q, rst_n_q;
  reg [4:0]  s1_q, s2_q;
  reg [12:0] mv1_q, mv2_q, mv3_q;
  reg        above_q;
  reg        sck_prev_q;
  reg [2:0]  state_q;
  reg [7:0]  sh_q;
  reg [5:0]  bits_q;
  reg [7:0]  op_q, addr_q;
  reg [7:0]  out_q;
  reg        wel_q, nv_ok_q, nv_load_q;
  reg [2:0]  nv_q;
  reg        nv_we_q;
  reg [3:0]  nv_addr_q;
  reg [7:0]  nv_wdata_q;
  wire [7:0] nv_rdata;

  wire cs_n  = s2_q[0];
  wire sck   = s2_q[1];
  wire si    = s2_q[2];
  wire hold_n = s2_q[3];
  wire wp_n  = s2_q[4];
  wire rise  = sck & ~sck_prev_q;
  wire fall  = ~sck & sck_prev_q;
  wire above = above_q;
  wire [7:0] shin = {sh_q[6:0], si};

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst1_q  <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst1_q  <= 1'b1;
      rst_n_q <= rst1_q;
    end
  end

  // two-stage synchronisers, first stage read only by second
  always @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_q  <= 5'h19;
      s2_q  <= 5'h19;
      mv1_q <= 13'h0000;
      mv2_q <= 13'h0000;
      mv3_q <= 13'h0000;
      above_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      s1_q  <= {WP_N, HOLD_N, SI, SCK, CS_N};
      s2_q  <= s1_q;
      mv1_q <= SUPPLY_MV;
      mv2_q <= mv1_q;
      mv3_q <= mv2_q;
      // bits of the supply word may land in different cycles:
      // only a value seen twice in a row is trusted
      if (mv2_q == mv3_q)
        above_q <= (mv2_q > `THRESHOLD_MV);
      sck_prev_q <= s2_q[1];
    end
  end

  nv_store u_nv (
    .clk   (MCLK),
    .we    (nv_we_q),
    .addr  (nv_addr_q),
    .wdata (nv_wdata_q),
    .rdata (nv_rdata)
  );

  wire [1:0] bp = nv_q[1:0];
  wire blocked = (bp == 2'h3) ||
                 (bp == 2'h2 && addr_q[3]) ||
                 (bp == 2'h1 && addr_q[3:2] == 2'h3);
  // protect flag only adds pin gating when set
  wire sr_lock = nv_q[2] & ~wp_n;

  always @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_RESET;
      sh_q <= 8'h00;
      bits_q <= 6'h00;
      op_q <= 8'h00;
      addr_q <= 8'h00;
      out_q <= 8'h00;
      wel_q <= `WEL_RESET;
      nv_ok_q <= 1'b0;
      nv_load_q <= 1'b0;
      nv_q <= `SHIP_NV;
      nv_we_q <= 1'b0;
      nv_addr_q <= 4'hf;
      nv_wdata_q <= 8'h00;
      SO_O <= 1'b0;
      SO_OE <= 1'b0;
      POWER_GOOD <= 1'b0;
      STANDBY <= 1'b1;
      STATUS <= 8'h00;
    end else begin
      nv_we_q <= 1'b0;
      // reload protection bits once after reset
      nv_load_q <= ~nv_ok_q;
      if (nv_load_q & ~nv_ok_q) begin
        nv_q <= nv_rdata[2:0];
        nv_ok_q <= 1'b1;
      end
      STATUS <= {nv_q[2], 3'h0, nv_q[1:0], wel_q, `BUSY_RESET};
      POWER_GOOD <= (state_q != ST_RESET);
      STANDBY <= (state_q != ST_XFER);
      case (state_q)
        ST_RESET: begin
          SO_OE <= 1'b0;
          if (above && nv_ok_q)
            state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          SO_OE <= 1'b0;
          bits_q <= 6'h00;
          if (!above)
            state_q <= ST_RESET;
          else if (!cs_n)
            state_q <= ST_XFER;
        end
        ST_XFER: begin
          if (cs_n || !above) begin
            state_q <= above ? ST_IDLE : ST_RESET;
            SO_OE <= 1'b0;
            if (bits_q == 6'd8 && op_q == `OP_WREN)
              wel_q <= 1'b1;
          end else if (hold_n) begin
            SO_OE <= (op_q == `OP_RDSR || op_q == `OP_READ) && bits_q >= 6'd8;
            if (rise) begin
              sh_q <= shin;
              if (bits_q != 6'd63)
                bits_q <= bits_q + 6'd1;
              if (bits_q == 6'd7) begin
                op_q <= shin;
                if (shin == `OP_WRDI)
                  wel_q <= 1'b0;
                if (shin == `OP_RDSR)
                  out_q <= STATUS;
              end
              if (bits_q == 6'd15 && op_q != `OP_WRSR) begin
                addr_q <= shin;
                nv_addr_q <= shin[3:0];
              end
              if (bits_q == 6'd15 && op_q == `OP_WRSR && wel_q && !sr_lock) begin
                nv_q <= {shin[`STAT_PROTECT_ENABLE_FLAG], shin[`STAT_BP_HI], shin[`STAT_BP_LO]};
                nv_addr_q <= 4'hf;
                nv_wdata_q <= {5'h00, shin[`STAT_PROTECT_ENABLE_FLAG], shin[`STAT_BP_HI], shin[`STAT_BP_LO]};
                nv_we_q <= 1'b1;
                wel_q <= 1'b0;
              end
              if (bits_q == 6'd23 && op_q == `OP_WRITE && wel_q && !blocked && addr_q[3:0] != 4'hf) begin
                nv_wdata_q <= shin;
                nv_we_q <= 1'b1;
                wel_q <= 1'b0;
              end
            end
            // read data leaves on the fall right after the address byte;
            // the address settles one rise earlier, leaving time for the memory
            if (fall && bits_q == 6'd16 && op_q == `OP_READ) begin
              SO_O <= nv_rdata[7];
              out_q <= {nv_rdata[6:0], 1'b0};
            end else if (fall && bits_q >= 6'd8) begin
              SO_O <= out_q[7];
              out_q <= {out_q[6:0], 1'b0};
            end
          end else
            SO_OE <= 1'b0;
        end
        default: state_q <= ST_RESET;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verif/spi_eeprom_power_up_reset_monitor.sv
/* port checker for the power-up block.
   assumes a bind onto every instance. */
`timescale 1ns/100ps
`default_nettype none
module pwr_monitor (
  input wire logic        MCLK,
  input wire logic        ARST_N,
  input wire logic [12:0] SUPPLY_MV,
  input wire logic        CS_N,
  input wire logic        HOLD_N,
  input wire logic        SO_OE,
  input wire logic        POWER_GOOD,
  input wire logic        STANDBY,
  input wire logic [7:0]  STATUS
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  wire sup_low = SUPPLY_MV <= 13'd1500;
  a_pg_off_low: assert property (sup_low [*8] |-> !POWER_GOOD)
    else $error("live below threshold");
  a_pg_on_high: assert property (!sup_low [*8] |-> ##[0:12] POWER_GOOD)
    else $error("no power good");
  a_wel_clear: assert property ($rose(POWER_GOOD) |-> !STATUS[1])
    else $error("latch set at power-up");
  a_busy_zero: assert property (!STATUS[0])
    else $error("busy set");
  a_standby_idle: assert property (CS_N [*8] |-> STANDBY)
    else $error("no standby");
  a_so_off_hold: assert property (!HOLD_N [*8] |-> !SO_OE)
    else $error("drives in pause");
  a_so_off_idle: assert property ((CS_N || !POWER_GOOD) [*8] |-> !SO_OE)
    else $error("drives when off");
  a_status_quiet: assert property ((CS_N && POWER_GOOD) [*8] |=> $stable(STATUS))
    else $error("status moved idle");
  c_pg_rise: cover property ($rose(POWER_GOOD));
  c_so_drive: cover property ($rose(SO_OE));
  c_wel_set: cover property ($rose(STATUS[1]));
endmodule
bind spi_eeprom_power_up_reset pwr_monitor u_mon (.MCLK(MCLK), .ARST_N(ARST_N), .SUPPLY_MV(SUPPLY_MV),
  .CS_N(CS_N), .HOLD_N(HOLD_N), .SO_OE(SO_OE), .POWER_GOOD(POWER_GOOD), .STANDBY(STANDBY), .STATUS(STATUS));
`default_nettype wire

// file: verif/spi_host.sv
/* spi host, mode 0, sck 48 ns, low between frames.
   assumes the bench keeps the power-up wait. */
`timescale 1ns/100ps
`default_nettype none
module spi_host (
  // pins
  output logic      CS_N,
  output logic      SCK,
  output logic      SI,
  input  wire logic SO_O
);
  initial begin
    CS_N = 1'b1;
    SCK  = 1'b0;
    SI   = 1'b0;
  end
  task automatic xfer(input logic [23:0] w, input int n, output logic [7:0] r);
    CS_N = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      SI = w[i];
      #24 SCK = 1'b1;
      r = {r[6:0], SO_O};
      #24 SCK = 1'b0;
    end
    #200 CS_N = 1'b1;
    // released line: no stale bit
    SI = ~SI;
    #200;
  endtask
  task automatic kick;
    CS_N = 1'b0;
    #200 CS_N = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// file: verif/spi_eeprom_power_up_reset_test.sv
/* bench: supply ramps, status and array reads.
   assumes the host model and bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t %h %h", $time, g, e); end end
module spi_eeprom_power_up_reset_test;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [12:0] supply = 13'd0;
  logic        hold_n = 1'b1;
  wire         cs_n, sck, si, so_o, so_oe, pg, stby;
  wire  [7:0]  stat;
  logic [7:0]  r, nv, d;
  logic [3:0]  a;
  logic        wp_n = 1'b1;
  int          n_mismatch = 0, n_compared = 0, cyc = 0;
  always #2 mclk = ~mclk;
  spi_eeprom_power_up_reset i_dut (.MCLK(mclk), .ARST_N(arst_n), .SUPPLY_MV(supply), .CS_N(cs_n),
    .SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(wp_n), .SO_O(so_o), .SO_OE(so_oe), .POWER_GOOD(pg),
    .STANDBY(stby), .STATUS(stat));
  spi_host i_host (.CS_N(cs_n), .SCK(sck), .SI(si), .SO_O(so_oe ? so_o : ~so_o));
  function automatic logic [7:0] nv_of(input logic [7:0] d);
    return d & 8'h8c;
  endfunction
  // protected region: all, upper half or upper quarter of the array
  function automatic logic [7:0] rd_exp(input logic [1:0] bp, input logic [3:0] adr, input logic [7:0] dat);
    if (bp == 2'h3 || (bp == 2'h2 && adr[3]) || (bp == 2'h1 && adr[3:2] == 2'h3))
      return 8'hff;
    return dat;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // bench-side power-up wait before selecting
  task automatic ramp;
    supply = 13'($urandom_range(1501, 8191));
    #100000;
    tick(1);
  endtask
  task automatic stop_test;
    $display("compared %0d bad %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    nv = 8'($urandom(27268));
    tick(4);
    arst_n = 1'b1;
    supply = 13'($urandom_range(0, 1500));
    i_host.xfer(24'h6, 8, r);
    `CHK(pg, 1'b0)
    ramp;
    `CHK(pg, 1'b1)
    `CHK(stby, 1'b1)
    `CHK(stat, 8'h00)
    i_host.xfer(24'h0500, 16, r);
    `CHK(r, 8'h00)
    $display("end power-up");
    i_host.kick;
    i_host.xfer(24'h6, 8, r);
    i_host.xfer(24'h0500, 16, r);
    `CHK(r, 8'h02)
    // protect flag set and pin low: status write refused, latch kept
    i_host.xfer(24'h0180, 16, r);
    wp_n = 1'b0;
    i_host.xfer(24'h6, 8, r);
    i_host.xfer(24'h010c, 16, r);
    i_host.xfer(24'h0500, 16, r);
    `CHK(r, 8'h82)
    wp_n = 1'b1;
    nv = nv_of(8'($urandom));
    i_host.xfer(24'({8'h1, nv}), 16, r);
    tick(8);
    `CHK(stat & 8'h8c, nv)
    hold_n = 1'b0;
    tick(12);
    hold_n = 1'b1;
    i_host.xfer({8'h3, 4'h0, 4'($urandom_range(0, 14)), 8'h0}, 24, r);
    `CHK(r, 8'hff)
    a = 4'($urandom_range(0, 14));
    d = 8'($urandom);
    i_host.xfer(24'h6, 8, r);
    i_host.xfer({8'h2, 4'h0, a, d}, 24, r);
    i_host.xfer({8'h3, 4'h0, a, 8'h0}, 24, r);
    `CHK(r, rd_exp(nv[3:2], a, d))
    i_host.xfer(24'h4, 8, r);
    i_host.xfer(24'h0500, 16, r);
    `CHK(r, nv)
    $display("end status");
    tick(1);
    arst_n = 1'b0;
    supply = 13'd0;
    tick(4);
    arst_n = 1'b1;
    ramp;
    `CHK(stat, nv)
    supply = 13'd1500;
    tick(12);
    `CHK(pg, 1'b0)
    $display("end cycle");
    stop_test;
  end
endmodule
`default_nettype wire
